//--- logic/wait_dma_request_logic.sv
// per-channel wait and dma request pin logic with its control registers
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: wait-on-transmit is D7=1 D6=0 D5=0; pin open-drain idle, low active.
// R2: writing a full transmit buffer asserts wait until the buffer empties.
// R3: transmit wait starts on write strobe, only for transmit buffer access.
// R4: wait release happens on a falling edge of the peripheral clock.
// R5: wait-on-receive is D7=1 D6=0 D5=1; empty read waits for character.
// R6: receive wait starts on read strobe, only for receive buffer access.
// R7: wait/request pin serves tx or rx; terminal-ready pin serves tx only.
// R8: tx dma request high while disabled; low when buffer empty once enabled.
// R9: tx request tracks buffer even with transmitter off; one fall per char.
// R10: software enables transmitter before enabling the transmit request.
// R11: after crc closing flag load, request pins pulse high one pclk cycle.
// R12: wait/request tx request drops on write strobe to transmit buffer.
// R13: misc bit D2 makes terminal-ready pin a tx request, low when empty.
// R14: with D2 clear, terminal-ready pin is inverse of transmit-control D7.
// R15: terminal-ready request follows real buffer; wait/request anticipates.
// R16: sdlc, ext-enable D0 and extended D4 give terminal-ready fast timing.
// R17: rx dma request is D7 D6 D5 all set; high while selected, not enabled.
// R18: rx request low while character in buffer; one fall per character.
// R19: locked special-condition fifo holds rx request high until error reset.
// R20: rx request drops on read strobe, only for receive buffer access.
// R21: controller treats each request falling edge as one character.
// R22: reset selects wait mode disabled, leaving wait/request open-drain.
// R23: tx dma request on wait/request is D7=1 D6=1 D5=0.
module wait_dma_request_logic
  import wait_dma_request_pkg::*;
(
  input wire logic clk,                 // system clock, 100 MHz
  input wire logic reset,               // synchronous, active high
  input wire regReq_t regReq,           // register port request
  output logic [7:0] regRdata,          // read data, cycle after read strobe
  input wire logic pclkPin,             // peripheral clock pin
  input wire logic hostWrN,             // host write strobe pin, active low
  input wire logic hostRdN,             // host read strobe pin, active low
  input wire logic txBufSel,            // current access targets tx buffer
  input wire logic rxBufSel,            // current access targets rx buffer
  input wire chanStatus_t chanStatus,   // transmitter and receiver state
  output logic waitReqOut,              // wait/request pin output level
  output logic waitReqOe,               // wait/request pin output enable
  output logic termReqN                 // terminal-ready/request pin
);

  // ------------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------------
  function automatic reqMode_t decodeMode(input logic [7:0] ctl);
    if (!ctl[WRC_FUNCT_BIT]) begin
      if (!ctl[WRC_ENABLE_BIT]) begin
        decodeMode = MODE_WAIT_OFF;
      end else if (ctl[WRC_RXTX_BIT]) begin
        decodeMode = MODE_WAIT_RX;
      end else begin
        decodeMode = MODE_WAIT_TX;
      end
    end else if (!ctl[WRC_ENABLE_BIT]) begin
      decodeMode = MODE_DMA_IDLE;
    end else if (ctl[WRC_RXTX_BIT]) begin
      decodeMode = MODE_DMA_RX;
    end else begin
      decodeMode = MODE_DMA_TX;
    end
  endfunction

  function automatic logic regHit(input regReq_t req, input logic [3:0] ofs);
    regHit = req.wr && (req.addr == ofs);
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] waitReqCtl_ff;
  logic [7:0] miscCtl_ff;
  logic [7:0] txCtl_ff;
  logic [7:0] extCtl_ff;
  logic [7:0] extStatEn_ff;
  logic [7:0] rdata_ff;
  logic [7:0] statusWord;
  reqMode_t mode;

  always_ff @(posedge clk) begin
    if (reset) begin
      waitReqCtl_ff <= RST_WAIT_REQUEST_CONTROL; // R22
      miscCtl_ff <= RST_MISC_CONTROL;
      txCtl_ff <= RST_TRANSMIT_CONTROL;
      extCtl_ff <= RST_EXTENDED_CONTROL;
      extStatEn_ff <= RST_EXT_STATUS_ENABLE;
    end else begin
      if (regHit(regReq, OFS_WAIT_REQUEST_CONTROL)) begin
        waitReqCtl_ff <= regReq.wdata;
      end
      if (regHit(regReq, OFS_MISC_CONTROL)) begin
        miscCtl_ff <= regReq.wdata;
      end
      if (regHit(regReq, OFS_TRANSMIT_CONTROL)) begin
        txCtl_ff <= regReq.wdata;
      end
      if (regHit(regReq, OFS_EXTENDED_CONTROL)) begin
        extCtl_ff <= regReq.wdata;
      end
      if (regHit(regReq, OFS_EXT_STATUS_ENABLE)) begin
        extStatEn_ff <= regReq.wdata;
      end
    end
  end

  assign mode = decodeMode(waitReqCtl_ff); // R1 R5 R17 R23

  // ------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  logic [2:0] pinPrev_ff;
  logic pclkFall;
  logic wrStart;
  logic rdStart;

  // bit 0 pclk, bit 1 write strobe, bit 2 read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      pinMeta_ff <= 3'h7;
      pinSync_ff <= 3'h7;
      pinPrev_ff <= 3'h7;
    end else begin
      pinMeta_ff <= {hostRdN, hostWrN, pclkPin};
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end

  // strobes are active low: their falling edge starts the access
  assign pclkFall = pinPrev_ff[0] && !pinSync_ff[0];
  assign wrStart = pinPrev_ff[1] && !pinSync_ff[1];
  assign rdStart = pinPrev_ff[2] && !pinSync_ff[2];

  logic txWrite;
  logic rxRead;
  assign txWrite = wrStart && txBufSel; // R3 R12
  assign rxRead = rdStart && rxBufSel; // R6 R20

  // ------------------------------------------------------------------
  // wait state
  // ------------------------------------------------------------------
  logic waitActive_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      waitActive_ff <= 1'b0;
    end else if (mode == MODE_WAIT_TX) begin
      if (txWrite && !chanStatus.txEmpty) begin
        waitActive_ff <= 1'b1; // R2 R3
      end else if (waitActive_ff && chanStatus.txEmpty && pclkFall) begin
        waitActive_ff <= 1'b0; // R2 R4
      end
    end else if (mode == MODE_WAIT_RX) begin
      if (rxRead && !chanStatus.rxAvail) begin
        waitActive_ff <= 1'b1; // R5 R6
      end else if (waitActive_ff && chanStatus.rxAvail && pclkFall) begin
        waitActive_ff <= 1'b0; // R5 R4
      end
    end else begin
      waitActive_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // transmit request tracking
  // ------------------------------------------------------------------
  // a write that fills the buffer is seen before the buffer reports
  // full; the pending flag stops a second falling edge in that gap
  logic txPend_ff;
  logic rxPend_ff;
  logic [1:0] crcFalls_ff;
  logic crcHigh;

  always_ff @(posedge clk) begin
    if (reset) begin
      txPend_ff <= 1'b0;
    end else if (txWrite) begin
      txPend_ff <= 1'b1; // R12 R15
    end else if (!chanStatus.txEmpty) begin
      txPend_ff <= 1'b0;
    end
  end

  // end-of-crc pulse, counted in peripheral clock falling edges
  always_ff @(posedge clk) begin
    if (reset) begin
      crcFalls_ff <= 2'h0;
    end else if (chanStatus.closingLoad &&
                 (chanStatus.sdlcMode || chanStatus.syncMode)) begin
      crcFalls_ff <= END_CRC_FALLS; // R11
    end else if (crcFalls_ff != 2'h0 && pclkFall) begin
      crcFalls_ff <= crcFalls_ff - 2'h1;
    end
  end
  assign crcHigh = (crcFalls_ff != 2'h0);

  // ------------------------------------------------------------------
  // receive request tracking
  // ------------------------------------------------------------------
  logic lockHold_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      rxPend_ff <= 1'b0;
    end else if (rxRead) begin
      rxPend_ff <= 1'b1; // R20
    end else if (!chanStatus.rxAvail) begin
      rxPend_ff <= 1'b0;
    end
  end

  // the locked character stays at the fifo top; holding the pin high
  // keeps the controller from reading it again and again
  always_ff @(posedge clk) begin
    if (reset) begin
      lockHold_ff <= 1'b0;
    end else if (rxRead && chanStatus.fifoLocked) begin
      lockHold_ff <= 1'b1; // R19
    end else if (chanStatus.errorReset) begin
      lockHold_ff <= 1'b0; // R19
    end
  end

  // ------------------------------------------------------------------
  // request levels (active high internally)
  // ------------------------------------------------------------------
  logic txReqEarly;
  logic txReqExact;
  logic rxReq;
  logic fastDeact;

  // follows the buffer regardless of transmitter enable
  assign txReqEarly = chanStatus.txEmpty && !txPend_ff && !crcHigh; // R9 R8
  assign txReqExact = chanStatus.txEmpty && !crcHigh; // R15 R13
  assign rxReq = chanStatus.rxAvail && !rxPend_ff && !lockHold_ff; // R18
  assign fastDeact = chanStatus.sdlcMode &&
                     extStatEn_ff[ESE_EXT_ENABLE_BIT] &&
                     extCtl_ff[EXT_FAST_DEACT_BIT]; // R16

  // ------------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------------
  logic waitReqOut_ff;
  logic waitReqOe_ff;
  logic termReqN_ff;
  logic nxt_waitReqOut;
  logic nxt_waitReqOe;
  logic nxt_termReqN;

  always_comb begin
    nxt_waitReqOut = 1'b1;
    nxt_waitReqOe = 1'b0;
    unique case (mode)
      MODE_WAIT_OFF: begin
        nxt_waitReqOe = 1'b0; // R22
      end
      MODE_WAIT_TX, MODE_WAIT_RX: begin
        nxt_waitReqOut = 1'b0; // R1
        nxt_waitReqOe = waitActive_ff; // R1
      end
      MODE_DMA_IDLE: begin
        nxt_waitReqOut = 1'b1; // R8 R17
        nxt_waitReqOe = 1'b1;
      end
      MODE_DMA_TX: begin
        nxt_waitReqOut = !txReqEarly; // R8 R7
        nxt_waitReqOe = 1'b1;
      end
      MODE_DMA_RX: begin
        nxt_waitReqOut = !rxReq; // R17 R7
        nxt_waitReqOe = 1'b1;
      end
      default: begin
        nxt_waitReqOut = 1'b1;
        nxt_waitReqOe = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (!miscCtl_ff[MISC_REQ_FUNCT_BIT]) begin
      nxt_termReqN = !txCtl_ff[TXC_TERM_READY_BIT]; // R14
    end else if (fastDeact) begin
      nxt_termReqN = !txReqEarly; // R16
    end else begin
      nxt_termReqN = !txReqExact; // R13 R15
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      waitReqOut_ff <= 1'b1;
      waitReqOe_ff <= 1'b0;
      termReqN_ff <= 1'b1; // R14
    end else begin
      waitReqOut_ff <= nxt_waitReqOut;
      waitReqOe_ff <= nxt_waitReqOe;
      termReqN_ff <= nxt_termReqN;
    end
  end

  assign waitReqOut = waitReqOut_ff;
  assign waitReqOe = waitReqOe_ff;
  assign termReqN = termReqN_ff;

  // ------------------------------------------------------------------
  // read back
  // ------------------------------------------------------------------
  assign statusWord = {2'h0, lockHold_ff, crcHigh, rxPend_ff, txPend_ff,
                       waitActive_ff, fastDeact};

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (regReq.rd) begin
      unique case (regReq.addr)
        OFS_STATUS: rdata_ff <= statusWord;
        OFS_WAIT_REQUEST_CONTROL: rdata_ff <= waitReqCtl_ff;
        OFS_TRANSMIT_CONTROL: rdata_ff <= txCtl_ff;
        OFS_EXTENDED_CONTROL: rdata_ff <= extCtl_ff;
        OFS_MISC_CONTROL: rdata_ff <= miscCtl_ff;
        OFS_EXT_STATUS_ENABLE: rdata_ff <= extStatEn_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign regRdata = rdata_ff;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // the pin flop lags the mode by one cycle, so the mode is taken a cycle
  // earlier; a direct switch from a driven-high request mode stays legal
  property p_wait_drive_low;
    @(posedge clk) disable iff (reset)
    (mode == MODE_WAIT_TX || mode == MODE_WAIT_RX) ##1 waitReqOe
      |-> !waitReqOut;
  endproperty
  a_wait_drive_low: assert property (p_wait_drive_low) // R1
    else $error("wait pin driven high in a wait mode");

  property p_wait_tx_set;
    @(posedge clk) disable iff (reset)
    mode == MODE_WAIT_TX && txWrite && !chanStatus.txEmpty
      |=> ##1 waitReqOe;
  endproperty
  a_wait_tx_set: assert property (p_wait_tx_set) // R2
    else $error("write to full buffer did not assert wait");

  property p_wait_no_target;
    @(posedge clk) disable iff (reset)
    mode == MODE_WAIT_TX && !waitActive_ff && wrStart && !txBufSel
      |=> !waitActive_ff;
  endproperty
  a_wait_no_target: assert property (p_wait_no_target) // R3
    else $error("wait asserted for an access to another register");

  property p_wait_release_fall;
    @(posedge clk) disable iff (reset)
    $fell(waitActive_ff) && (mode == MODE_WAIT_TX || mode == MODE_WAIT_RX)
      |-> $past(pclkFall);
  endproperty
  a_wait_release_fall: assert property (p_wait_release_fall) // R4
    else $error("wait released away from a pclk falling edge");

  property p_wait_rx_set;
    @(posedge clk) disable iff (reset)
    mode == MODE_WAIT_RX && rxRead && !chanStatus.rxAvail
      |=> waitActive_ff ##1 waitReqOe;
  endproperty
  a_wait_rx_set: assert property (p_wait_rx_set) // R5
    else $error("read of empty fifo did not assert wait");

  property p_dma_idle_high;
    @(posedge clk) disable iff (reset)
    mode == MODE_DMA_IDLE ##1 mode == MODE_DMA_IDLE
      |-> waitReqOe && waitReqOut;
  endproperty
  a_dma_idle_high: assert property (p_dma_idle_high) // R8
    else $error("selected but disabled request not driven high");

  property p_tx_write_drop;
    @(posedge clk) disable iff (reset)
    mode == MODE_DMA_TX && txWrite ##1 mode == MODE_DMA_TX
      |=> waitReqOut;
  endproperty
  a_tx_write_drop: assert property (p_tx_write_drop) // R12
    else $error("tx request not dropped by buffer write");

  property p_crc_pulse;
    @(posedge clk) disable iff (reset)
    chanStatus.closingLoad && (chanStatus.sdlcMode || chanStatus.syncMode)
      |=> crcHigh [*2];
  endproperty
  a_crc_pulse: assert property (p_crc_pulse) // R11
    else $error("end of crc pulse missing");

  property p_term_gpio;
    @(posedge clk) disable iff (reset)
    !miscCtl_ff[MISC_REQ_FUNCT_BIT] ##1 !$past(miscCtl_ff[MISC_REQ_FUNCT_BIT])
      |-> termReqN == !$past(txCtl_ff[TXC_TERM_READY_BIT]);
  endproperty
  a_term_gpio: assert property (p_term_gpio) // R14
    else $error("terminal-ready pin not inverse of its control bit");

  property p_lock_hold;
    @(posedge clk) disable iff (reset)
    lockHold_ff && mode == MODE_DMA_RX ##1 mode == MODE_DMA_RX
      |-> waitReqOut;
  endproperty
  a_lock_hold: assert property (p_lock_hold) // R19
    else $error("rx request active while fifo is locked");

  property p_rx_read_drop;
    @(posedge clk) disable iff (reset)
    mode == MODE_DMA_RX && rxRead ##1 mode == MODE_DMA_RX
      |=> waitReqOut;
  endproperty
  a_rx_read_drop: assert property (p_rx_read_drop) // R20
    else $error("rx request not dropped by buffer read");

endmodule

`default_nettype wire

//--- logic/wait_dma_request_pkg.sv
// shared constants, types and field layouts of the wait / dma request block
package wait_dma_request_pkg;

  // ------------------------------------------------------------------
  // register offsets on the plain register port
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_WAIT_REQUEST_CONTROL = 4'h1;
  localparam logic [3:0] OFS_TRANSMIT_CONTROL = 4'h5;
  localparam logic [3:0] OFS_EXTENDED_CONTROL = 4'h7;
  localparam logic [3:0] OFS_MISC_CONTROL = 4'he;
  localparam logic [3:0] OFS_EXT_STATUS_ENABLE = 4'hf;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int WRC_ENABLE_BIT = 7;
  localparam int WRC_FUNCT_BIT = 6;
  localparam int WRC_RXTX_BIT = 5;
  localparam int MISC_REQ_FUNCT_BIT = 2;
  localparam int TXC_TERM_READY_BIT = 7;
  localparam int ESE_EXT_ENABLE_BIT = 0;
  localparam int EXT_FAST_DEACT_BIT = 4;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_WAIT_REQUEST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MISC_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_CONTROL = 8'h00;
  localparam logic [7:0] RST_EXTENDED_CONTROL = 8'h00;
  localparam logic [7:0] RST_EXT_STATUS_ENABLE = 8'h00;

  // ------------------------------------------------------------------
  // timing: end-of-crc high pulse lasts one peripheral clock period,
  // i.e. it ends on the second peripheral clock falling edge
  // ------------------------------------------------------------------
  localparam int END_CRC_PCLK_CYCLES = 1;
  localparam logic [1:0] END_CRC_FALLS = 2'(END_CRC_PCLK_CYCLES + 1);

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_WAIT_OFF = 6'h01,
    MODE_WAIT_TX = 6'h02,
    MODE_WAIT_RX = 6'h04,
    MODE_DMA_IDLE = 6'h08,
    MODE_DMA_TX = 6'h10,
    MODE_DMA_RX = 6'h20
  } reqMode_t;

  // state reported by the transmitter and receiver of this channel
  typedef struct packed {
    logic txEmpty;      // transmit buffer empty
    logic rxAvail;      // character at top of receive fifo
    logic fifoLocked;   // special-condition character locked the fifo
    logic errorReset;   // one-cycle pulse: error reset command issued
    logic closingLoad;  // one-cycle pulse: closing flag/sync after crc
    logic sdlcMode;     // bit-oriented mode selected
    logic syncMode;     // character-oriented sync mode selected
  } chanStatus_t;

  // register port
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } regReq_t;

endpackage

//--- sim/host_dma_model.sv
// behavioural host processor / dma controller facing the wait/request pin
`timescale 1ns/10ps
`default_nettype none
module host_dma_model (
  input wire logic clk,           // system clock
  input wire logic reset,         // synchronous, active high
  input wire logic go,            // one-cycle start of an access
  input wire logic goWrite,       // access is a write, else a read
  input wire logic goSel,         // access targets the data buffer
  input wire logic holdOnWait,    // processor honours the wait pin
  input wire logic waitReqOut,    // wait/request pin output level
  input wire logic waitReqOe,     // wait/request pin output enable
  output logic hostWrN,           // write strobe, active low
  output logic hostRdN,           // read strobe, active low
  output logic txBufSel,          // access targets transmit buffer
  output logic rxBufSel,          // access targets receive buffer
  output logic busy,              // access in progress
  output logic [7:0] fallCount    // falling edges seen on the pin
);
  logic [3:0] cnt;
  logic pinPrev;
  logic pinLevel;
  // open-drain line with a pull-up: released reads high
  assign pinLevel = waitReqOe ? waitReqOut : 1'b1;
  always_ff @(posedge clk) begin
    if (reset) begin
      hostWrN <= 1'b1;
      hostRdN <= 1'b1;
      txBufSel <= 1'b0;
      rxBufSel <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
    end else if (go) begin
      cnt <= 4'h8;
      hostWrN <= !goWrite;
      hostRdN <= goWrite;
      txBufSel <= goWrite & goSel;
      rxBufSel <= !goWrite & goSel;
      busy <= 1'b1;
    end else if (busy) begin
      // a stalled processor keeps strobe and select while wait is low
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pinLevel || !holdOnWait) begin
        hostWrN <= 1'b1;
        hostRdN <= 1'b1;
        txBufSel <= 1'b0;
        rxBufSel <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
  // each falling edge is one character requested
  always_ff @(posedge clk) begin
    pinPrev <= reset ? 1'b1 : pinLevel;
    if (reset) begin
      fallCount <= 8'h00;
    end else if (pinPrev && !pinLevel) begin
      fallCount <= fallCount + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- sim/wait_dma_request_logic_tb.sv
// self-checking bench of the wait / dma request logic
`timescale 1ns/10ps
`default_nettype none
module wait_dma_request_logic_tb
  import wait_dma_request_pkg::*;
();
  logic clk, reset, pclkPin, go, goWrite, goSel, holdOnWait, busy;
  logic hostWrN, hostRdN, txBufSel, rxBufSel;
  logic waitReqOut, waitReqOe, termReqN;
  logic [7:0] regRdata, fallCount;
  logic [1:0] pdiv;
  logic [31:0] rnd;
  regReq_t regReq;
  chanStatus_t chanStatus;
  int fail_count, n_checks, cycles;

  wait_dma_request_logic DUT (.clk(clk), .reset(reset), .regReq(regReq),
    .regRdata(regRdata), .pclkPin(pclkPin), .hostWrN(hostWrN),
    .hostRdN(hostRdN), .txBufSel(txBufSel), .rxBufSel(rxBufSel),
    .chanStatus(chanStatus), .waitReqOut(waitReqOut),
    .waitReqOe(waitReqOe), .termReqN(termReqN));
  host_dma_model host (.clk(clk), .reset(reset), .go(go),
    .goWrite(goWrite), .goSel(goSel), .holdOnWait(holdOnWait),
    .waitReqOut(waitReqOut), .waitReqOe(waitReqOe), .hostWrN(hostWrN),
    .hostRdN(hostRdN), .txBufSel(txBufSel), .rxBufSel(rxBufSel),
    .busy(busy), .fallCount(fallCount));

  // ------------------------------------------------------------------
  // clocks, timeout and helpers
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // peripheral clock: six system cycles a period, edges on system clock rising edges
  always @(posedge clk) begin
    pdiv <= (pdiv == 2'h2) ? 2'h0 : pdiv + 2'h1;
    if (pdiv == 2'h2) pclkPin <= !pclkPin;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // pins as {output enable, wait/request level, terminal-ready level}
  task automatic pins(input logic [2:0] e);
    step(12);
    chk({5'h0, waitReqOe, waitReqOut, termReqN}, {5'h0, e});
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask
  task automatic hostGo(input logic w, input logic s, input logic h);
    @(posedge clk);
    go <= 1'b1;
    goWrite <= w;
    goSel <= s;
    holdOnWait <= h;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic hostIdle();
    int k;
    k = 0;
    #1;
    while (busy && k < 300) begin
      @(posedge clk);
      k++;
    end
    #1;
    chk({7'h0, busy}, 8'h00);
  endtask
  task automatic access(input logic w, input logic s);
    hostGo(w, s, 1'b0);
    hostIdle();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {reset, pclkPin, go, goWrite, goSel, holdOnWait} = 6'b110000;
    {pdiv, regReq, chanStatus, fail_count, n_checks, cycles} = '0;
    rnd = 32'h0fe0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    pins(3'b011);
    rdReg(OFS_WAIT_REQUEST_CONTROL, 8'h00);
    rdReg(4'h3, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wrReg(OFS_EXTENDED_CONTROL, rnd[7:0]);
      rdReg(OFS_EXTENDED_CONTROL, rnd[7:0]);
    end
    wrReg(OFS_EXTENDED_CONTROL, 8'h00);
    wrReg(OFS_TRANSMIT_CONTROL, 8'h80);
    pins(3'b010);
    wrReg(OFS_TRANSMIT_CONTROL, 8'h00);
    pins(3'b011);
    @(posedge clk) chanStatus.txEmpty <= 1'b1;
    wrReg(OFS_MISC_CONTROL, 8'h04);
    pins(3'b010);
    rdReg(OFS_MISC_CONTROL, 8'h04);
    @(posedge clk) chanStatus.txEmpty <= 1'b0;
    pins(3'b011);
    wrReg(OFS_MISC_CONTROL, 8'h00);
    // transmitter taken as running; select first, enable second
    wrReg(OFS_WAIT_REQUEST_CONTROL, 8'h40);
    pins(3'b111);
    wrReg(OFS_WAIT_REQUEST_CONTROL, 8'hc0);
    pins(3'b111);
    @(posedge clk) chanStatus.txEmpty <= 1'b1;
    pins(3'b101);
    access(1'b1, 1'b0);
    pins(3'b101);
    access(1'b1, 1'b1);
    pins(3'b111);
    @(posedge clk) chanStatus.txEmpty <= 1'b0;
    pins(3'b111);
    @(posedge clk) chanStatus.txEmpty <= 1'b1;
    pins(3'b101);
    chk(fallCount, 8'h02);
    @(posedge clk) chanStatus.syncMode <= 1'b1;
    @(posedge clk) chanStatus.closingLoad <= 1'b1;
    @(posedge clk) chanStatus.closingLoad <= 1'b0;
    step(2);
    chk({7'h0, waitReqOut}, 8'h01);
    pins(3'b101);
    @(posedge clk) chanStatus.syncMode <= 1'b0;
    wrReg(OFS_WAIT_REQUEST_CONTROL, 8'h60);
    pins(3'b111);
    wrReg(OFS_WAIT_REQUEST_CONTROL, 8'he0);
    pins(3'b111);
    @(posedge clk) chanStatus.rxAvail <= 1'b1;
    pins(3'b101);
    access(1'b0, 1'b0);
    pins(3'b101);
    access(1'b0, 1'b1);
    pins(3'b111);
    @(posedge clk) chanStatus.rxAvail <= 1'b0;
    pins(3'b111);
    @(posedge clk) chanStatus <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    pins(3'b101);
    access(1'b0, 1'b1);
    @(posedge clk) chanStatus.rxAvail <= 1'b0;
    pins(3'b111);
    @(posedge clk) chanStatus.rxAvail <= 1'b1;
    pins(3'b111);
    @(posedge clk) chanStatus <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    @(posedge clk) chanStatus.errorReset <= 1'b0;
    pins(3'b101);
    wrReg(OFS_WAIT_REQUEST_CONTROL, 8'h00);
    wrReg(OFS_WAIT_REQUEST_CONTROL, 8'h80);
    @(posedge clk) chanStatus.txEmpty <= 1'b0;
    // wait modes: released pin is undriven with its level held low
    pins(3'b001);
    access(1'b1, 1'b0);
    pins(3'b001);
    hostGo(1'b1, 1'b1, 1'b1);
    pins(3'b101);
    @(posedge clk) chanStatus.txEmpty <= 1'b1;
    hostIdle();
    pins(3'b001);
    wrReg(OFS_WAIT_REQUEST_CONTROL, 8'ha0);
    rdReg(OFS_WAIT_REQUEST_CONTROL, 8'ha0);
    @(posedge clk) chanStatus.rxAvail <= 1'b0;
    access(1'b0, 1'b0);
    pins(3'b001);
    hostGo(1'b0, 1'b1, 1'b1);
    pins(3'b101);
    @(posedge clk) chanStatus.rxAvail <= 1'b1;
    hostIdle();
    pins(3'b001);
    // terminal-ready request: exact tracking, then the anticipating option
    wrReg(OFS_MISC_CONTROL, 8'h04);
    access(1'b1, 1'b1);
    pins(3'b000);
    @(posedge clk) chanStatus.sdlcMode <= 1'b1;
    wrReg(OFS_EXT_STATUS_ENABLE, 8'h01);
    wrReg(OFS_EXTENDED_CONTROL, 8'h10);
    pins(3'b001);
    rdReg(OFS_STATUS, 8'h05);
    @(posedge clk) chanStatus.txEmpty <= 1'b0;
    @(posedge clk) chanStatus.txEmpty <= 1'b1;
    pins(3'b000);
    conclude();
  end
endmodule
`default_nettype wire
